// >>> hdl/evm_exception_mapper.sv
// Exception sequencer: stacking, vector number to table address, vector fetch
`timescale 1ns/100ps
`default_nettype none

module evm_exception_mapper
  import evm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic berr_pin_i,
  input wire logic bkpt_pin_i,
  input wire logic [2:0] irq_level_pin_i,
  input wire logic swi_i,
  input wire logic illegal_i,
  input wire logic div_zero_i,
  input wire logic [2:0] irq_mask_i,
  input wire logic insn_boundary_i,
  input wire logic [19:0] next_insn_addr_i,
  input wire logic [15:0] condition_flags_register_i,
  input wire logic [15:0] sp_i,
  input wire logic [3:0] stack_bank_field_i,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic iack_ack_i,
  input wire logic iack_autovec_i,
  input wire logic iack_spurious_i,
  input wire logic iack_uninit_i,
  input wire logic [7:0] iack_vector_i,
  output logic mem_req_o,
  output logic mem_write_o,
  output logic mem_program_space_o,
  output logic [19:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic iack_req_o,
  output logic [2:0] iack_level_o,
  output logic busy_o,
  output logic handler_start_o,
  output logic reset_done_o,
  output logic [7:0] vector_number_o,
  output logic [15:0] pc_o,
  output logic [3:0] program_bank_field_o,
  output logic [3:0] stack_bank_field_o,
  output logic [3:0] z_index_bank_field_o,
  output logic [15:0] sp_o,
  output logic [15:0] z_index_register_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second

  localparam int SYNC_W = 5;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;

  assign pin_raw = {irq_level_pin_i, bkpt_pin_i, berr_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge mclk_i)
      begin
        if (!nrst_i)
        begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic berr_s;
  logic bkpt_s;
  logic [2:0] irq_level_s;
  logic berr_d;
  logic bkpt_d;

  assign berr_s = pin_sync[0];
  assign bkpt_s = pin_sync[1];
  assign irq_level_s = pin_sync[4:2];

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      berr_d <= 1'b0;
      bkpt_d <= 1'b0;
    end
    else
    begin
      berr_d <= berr_s;
      bkpt_d <= bkpt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending exceptions; a new event beats the clear of the same cycle

  evm_state_t state;
  evm_state_t next_state;
  logic berr_pend;
  logic bkpt_pend;
  logic swi_pend;
  logic illegal_pend;
  logic div_zero_pend;
  logic irq_ok;
  logic sel_valid;
  evm_kind_t sel_kind;
  logic [7:0] sel_vec;
  logic sel_async;
  logic take;

  // Level 7 cannot be masked
  assign irq_ok = (irq_level_s != 3'h0)
    && ((irq_level_s > irq_mask_i) || (irq_level_s == EVM_LEVEL_NMI));
  assign take = (state == EVM_S_IDLE) && insn_boundary_i && sel_valid;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      berr_pend <= 1'b0;
      bkpt_pend <= 1'b0;
      swi_pend <= 1'b0;
      illegal_pend <= 1'b0;
      div_zero_pend <= 1'b0;
    end
    else
    begin
      berr_pend <= (berr_s && !berr_d) || (berr_pend && !(take && sel_kind == EVM_K_BERR));
      bkpt_pend <= (bkpt_s && !bkpt_d) || (bkpt_pend && !(take && sel_kind == EVM_K_BKPT));
      swi_pend <= swi_i || (swi_pend && !(take && sel_kind == EVM_K_SWI));
      illegal_pend <= illegal_i || (illegal_pend && !(take && sel_kind == EVM_K_ILLEGAL));
      div_zero_pend <= div_zero_i
        || (div_zero_pend && !(take && sel_kind == EVM_K_DIV_ZERO));
    end
  end

  evm_vector_select u_select (
    .berr_pend_i(berr_pend),
    .bkpt_pend_i(bkpt_pend),
    .irq_ok_i(irq_ok),
    .swi_pend_i(swi_pend),
    .illegal_pend_i(illegal_pend),
    .div_zero_pend_i(div_zero_pend),
    .sel_valid_o(sel_valid),
    .sel_kind_o(sel_kind),
    .sel_vec_o(sel_vec),
    .sel_async_o(sel_async)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic mem_done;
  logic iack_done;
  evm_kind_t kind;
  logic [7:0] next_vec;

  assign mem_done = mem_req_o && mem_ack_i;
  assign iack_done = iack_req_o && iack_ack_i;

  always_comb
  begin
    next_vec = vector_number_o;
    if (take)
      next_vec = sel_vec;
    else if (state == EVM_S_IACK && iack_done)
    begin
      if (iack_spurious_i)
        next_vec = EVM_VEC_SPURIOUS;
      else if (iack_uninit_i)
        next_vec = EVM_VEC_UNINIT;
      else if (iack_autovec_i)
        next_vec = EVM_VEC_AUTOVEC_BASE + {5'h00, iack_level_o};
      else
        next_vec = iack_vector_i;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      EVM_S_IDLE:
        if (take)
          next_state = EVM_S_PUSH_FLAGS;
      EVM_S_PUSH_FLAGS:
        if (mem_done)
          next_state = EVM_S_PUSH_PC;
      EVM_S_PUSH_PC:
        if (mem_done)
          next_state = (kind == EVM_K_IRQ) ? EVM_S_IACK : EVM_S_VFETCH;
      EVM_S_IACK:
        if (iack_done)
          next_state = EVM_S_VFETCH;
      EVM_S_VFETCH:
        if (mem_done)
          next_state = EVM_S_DONE;
      EVM_S_RST0:
        if (mem_done)
          next_state = EVM_S_RST1;
      EVM_S_RST1:
        if (mem_done)
          next_state = EVM_S_RST2;
      EVM_S_RST2:
        if (mem_done)
          next_state = EVM_S_RST3;
      EVM_S_RST3:
        if (mem_done)
          next_state = EVM_S_DONE;
      // one cycle of hand-off, then idle
      EVM_S_DONE:
        next_state = EVM_S_IDLE;
      default:
        next_state = EVM_S_IDLE;
    endcase
  end

  // Reset exception starts the four-word fetch right after release
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      state <= EVM_S_RST0;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured context

  logic [19:0] ret_addr;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      kind <= EVM_K_NONE;
      vector_number_o <= EVM_RST_VEC;
      ret_addr <= 20'h00000;
    end
    else
    begin
      vector_number_o <= next_vec;
      if (take)
      begin
        kind <= sel_kind;
        ret_addr <= sel_async ? next_insn_addr_i + EVM_RET_OFFSET : next_insn_addr_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port: one request held until acknowledged

  logic [15:0] vec_offset;

  // 8-bit number reaches all 256 entries
  assign vec_offset = {7'h00, next_vec, 1'b0};

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      mem_req_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_program_space_o <= 1'b0;
      mem_addr_o <= 20'h00000;
      mem_wdata_o <= EVM_RST_WORD;
    end
    else if (state != next_state || (state == EVM_S_RST0 && !mem_req_o && !mem_done))
    begin
      mem_req_o <= 1'b1;
      mem_write_o <= 1'b0;
      mem_program_space_o <= 1'b0;
      case (next_state)
        // push at stack bank : SP, flags first
        EVM_S_PUSH_FLAGS:
        begin
          mem_write_o <= 1'b1;
          mem_addr_o <= {stack_bank_field_i, sp_i};
          mem_wdata_o <= condition_flags_register_i;
        end
        EVM_S_PUSH_PC:
        begin
          mem_write_o <= 1'b1;
          mem_addr_o <= {stack_bank_field_o, sp_o - EVM_STACK_STEP};
          mem_wdata_o <= ret_addr[15:0];
        end
        EVM_S_VFETCH:
          mem_addr_o <= {EVM_TABLE_BANK, vec_offset};
        EVM_S_RST0:
        begin
          mem_program_space_o <= 1'b1;
          mem_addr_o <= {EVM_TABLE_BANK, EVM_RST_WORD0_ADDR};
        end
        EVM_S_RST1:
        begin
          mem_program_space_o <= 1'b1;
          mem_addr_o <= {EVM_TABLE_BANK, EVM_RST_WORD1_ADDR};
        end
        EVM_S_RST2:
        begin
          mem_program_space_o <= 1'b1;
          mem_addr_o <= {EVM_TABLE_BANK, EVM_RST_WORD2_ADDR};
        end
        EVM_S_RST3:
        begin
          mem_program_space_o <= 1'b1;
          mem_addr_o <= {EVM_TABLE_BANK, EVM_RST_WORD3_ADDR};
        end
        default:
          mem_req_o <= 1'b0;
      endcase
    end
    else if (mem_done)
      mem_req_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt acknowledge towards the interrupting device

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      iack_req_o <= 1'b0;
      iack_level_o <= 3'h0;
    end
    else
    begin
      if (take)
        iack_level_o <= irq_level_s;
      if (state == EVM_S_PUSH_PC && next_state == EVM_S_IACK)
        iack_req_o <= 1'b1;
      else if (iack_done)
        iack_req_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor state loaded for the handler

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      pc_o <= EVM_RST_WORD;
      sp_o <= EVM_RST_WORD;
      z_index_register_o <= EVM_RST_WORD;
      program_bank_field_o <= EVM_RST_BANK;
      stack_bank_field_o <= EVM_RST_BANK;
      z_index_bank_field_o <= EVM_RST_BANK;
    end
    else
    begin
      case (state)
        EVM_S_IDLE:
          if (take)
          begin
            sp_o <= sp_i;
            stack_bank_field_o <= stack_bank_field_i;
            program_bank_field_o <= condition_flags_register_i[EVM_FLAGS_PBANK_LSB +: 4];
          end
        EVM_S_PUSH_FLAGS:
          if (mem_done)
            sp_o <= sp_o - EVM_STACK_STEP;
        EVM_S_PUSH_PC:
          if (mem_done)
          begin
            sp_o <= sp_o - EVM_STACK_STEP;
            program_bank_field_o <= EVM_RST_BANK;
          end
        EVM_S_VFETCH:
          if (mem_done)
            pc_o <= mem_rdata_i;
        // bank fields, PC, SP from reset words
        EVM_S_RST0:
          if (mem_done)
          begin
            z_index_bank_field_o <= mem_rdata_i[EVM_ZBANK_LSB +: 4];
            stack_bank_field_o <= mem_rdata_i[EVM_SBANK_LSB +: 4];
            program_bank_field_o <= mem_rdata_i[EVM_PBANK_LSB +: 4];
          end
        EVM_S_RST1:
          if (mem_done)
            pc_o <= mem_rdata_i;
        EVM_S_RST2:
          if (mem_done)
            sp_o <= mem_rdata_i;
        EVM_S_RST3:
          if (mem_done)
            z_index_register_o <= mem_rdata_i;
        default:
          pc_o <= pc_o;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status towards the core

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      busy_o <= 1'b1;
      handler_start_o <= 1'b0;
      reset_done_o <= 1'b0;
    end
    else
    begin
      busy_o <= (next_state != EVM_S_IDLE) && (next_state != EVM_S_DONE);
      handler_start_o <= (next_state == EVM_S_DONE);
      reset_done_o <= (state == EVM_S_RST3) && mem_done;
    end
  end

endmodule // evm_exception_mapper

`default_nettype wire

// >>> hdl/evm_pkg.sv
// Constants, encodings and state types of the exception vector mapper
package evm_pkg;

  localparam int EVM_ADDR_W = 20;
  localparam int EVM_DATA_W = 16;
  localparam int EVM_VEC_W = 8;
  localparam int EVM_BANK_W = 4;

  // Vector table layout
  localparam int EVM_TABLE_BYTES = 512;
  localparam int EVM_PREDEF_VECTORS = 52;
  localparam int EVM_USER_VECTORS = 200;
  localparam logic [3:0] EVM_TABLE_BANK = 4'h0;
  localparam logic [15:0] EVM_RST_WORD0_ADDR = 16'h0000;
  localparam logic [15:0] EVM_RST_WORD1_ADDR = 16'h0002;
  localparam logic [15:0] EVM_RST_WORD2_ADDR = 16'h0004;
  localparam logic [15:0] EVM_RST_WORD3_ADDR = 16'h0006;

  // Fixed internal vector numbers
  localparam logic [7:0] EVM_VEC_RESET = 8'h00;
  localparam logic [7:0] EVM_VEC_BKPT = 8'h04;
  localparam logic [7:0] EVM_VEC_BERR = 8'h05;
  localparam logic [7:0] EVM_VEC_SWI = 8'h06;
  localparam logic [7:0] EVM_VEC_ILLEGAL = 8'h07;
  localparam logic [7:0] EVM_VEC_DIV_ZERO = 8'h08;
  localparam logic [7:0] EVM_VEC_UNINIT = 8'h0F;
  localparam logic [7:0] EVM_VEC_AUTOVEC_BASE = 8'h10;
  localparam logic [7:0] EVM_VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] EVM_VEC_USER_FIRST = 8'h38;

  // Field positions inside reset word 0 and the flags register
  localparam int EVM_ZBANK_LSB = 8;
  localparam int EVM_SBANK_LSB = 4;
  localparam int EVM_PBANK_LSB = 0;
  localparam int EVM_FLAGS_PBANK_LSB = 0;

  // Stacking
  localparam logic [19:0] EVM_RET_OFFSET = 20'h00006;
  localparam logic [15:0] EVM_STACK_STEP = 16'h0002;
  localparam logic [2:0] EVM_LEVEL_NMI = 3'h7;

  // Reset values
  localparam logic [15:0] EVM_RST_WORD = 16'h0000;
  localparam logic [3:0] EVM_RST_BANK = 4'h0;
  localparam logic [7:0] EVM_RST_VEC = 8'h00;

  typedef enum logic [2:0] {
    EVM_K_NONE = 3'h0,
    EVM_K_BERR = 3'h1,
    EVM_K_BKPT = 3'h2,
    EVM_K_IRQ = 3'h3,
    EVM_K_SWI = 3'h4,
    EVM_K_ILLEGAL = 3'h5,
    EVM_K_DIV_ZERO = 3'h6
  } evm_kind_t;

  // Gray codes along the interrupt path IDLE to DONE and through RST0 to RST3
  typedef enum logic [3:0] {
    EVM_S_IDLE = 4'h0,
    EVM_S_PUSH_FLAGS = 4'h1,
    EVM_S_PUSH_PC = 4'h3,
    EVM_S_IACK = 4'h2,
    EVM_S_VFETCH = 4'h6,
    EVM_S_DONE = 4'h7,
    EVM_S_RST0 = 4'hC,
    EVM_S_RST1 = 4'hD,
    EVM_S_RST2 = 4'hF,
    EVM_S_RST3 = 4'hE
  } evm_state_t;

endpackage

// >>> hdl/evm_vector_select.sv
// Priority selection of the pending exception and its internal vector number
`timescale 1ns/100ps
`default_nettype none

module evm_vector_select
  import evm_pkg::*;
(
  input wire logic berr_pend_i,
  input wire logic bkpt_pend_i,
  input wire logic irq_ok_i,
  input wire logic swi_pend_i,
  input wire logic illegal_pend_i,
  input wire logic div_zero_pend_i,
  output logic sel_valid_o,
  output evm_kind_t sel_kind_o,
  output logic [7:0] sel_vec_o,
  output logic sel_async_o
);

  always_comb
  begin
    sel_valid_o = 1'b1;
    sel_async_o = 1'b1;
    sel_kind_o = EVM_K_NONE;
    sel_vec_o = EVM_RST_VEC;
    if (berr_pend_i)
    begin
      sel_kind_o = EVM_K_BERR;
      sel_vec_o = EVM_VEC_BERR;
    end
    else if (bkpt_pend_i)
    begin
      sel_kind_o = EVM_K_BKPT;
      sel_vec_o = EVM_VEC_BKPT;
    end
    else if (irq_ok_i)
    begin
      // Vector number comes later from the acknowledge cycle
      sel_kind_o = EVM_K_IRQ;
    end
    else if (swi_pend_i)
    begin
      sel_kind_o = EVM_K_SWI;
      sel_vec_o = EVM_VEC_SWI;
      sel_async_o = 1'b0;
    end
    else if (illegal_pend_i)
    begin
      sel_kind_o = EVM_K_ILLEGAL;
      sel_vec_o = EVM_VEC_ILLEGAL;
      sel_async_o = 1'b0;
    end
    else if (div_zero_pend_i)
    begin
      sel_kind_o = EVM_K_DIV_ZERO;
      sel_vec_o = EVM_VEC_DIV_ZERO;
      sel_async_o = 1'b0;
    end
    else
    begin
      sel_valid_o = 1'b0;
      sel_async_o = 1'b0;
    end
  end

endmodule // evm_vector_select

`default_nettype wire

// >>> verification/evm_exception_mapper_properties.sv
// Concurrent checks on the exception mapper ports
`timescale 1ns/100ps
`default_nettype none

module evm_mapper_properties
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic iack_ack_i,
  input wire logic iack_autovec_i,
  input wire logic iack_spurious_i,
  input wire logic iack_uninit_i,
  input wire logic mem_req_o,
  input wire logic mem_write_o,
  input wire logic mem_program_space_o,
  input wire logic [19:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic iack_req_o,
  input wire logic [2:0] iack_level_o,
  input wire logic busy_o,
  input wire logic handler_start_o,
  input wire logic reset_done_o,
  input wire logic [7:0] vector_number_o,
  input wire logic [15:0] pc_o,
  input wire logic [3:0] program_bank_field_o,
  input wire logic [15:0] z_index_register_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  table_region_a: assert property (mem_req_o && !mem_write_o |-> mem_addr_o < 20'h00200)
    else $error("vector read outside table");
  vector_addr_a: assert property (mem_req_o && !mem_write_o && !mem_program_space_o
    |-> mem_addr_o == {11'h000, vector_number_o, 1'h0}) else $error("bad vector address");
  prog_space_a: assert property (mem_req_o && mem_program_space_o
    |-> !mem_write_o && mem_addr_o[19:3] == 17'h00000 && !mem_addr_o[0])
    else $error("bad program space access");
  reset_start_a: assert property ($rose(nrst_i) |=> mem_req_o && mem_program_space_o
    && mem_addr_o == 20'h00000) else $error("reset fetch not at word zero");
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_wdata_o) && $stable(mem_write_o))
    else $error("request dropped early");
  iack_hold_a: assert property (iack_req_o && !iack_ack_i |=> iack_req_o
    && $stable(iack_level_o)) else $error("acknowledge dropped early");
  handler_end_a: assert property (handler_start_o |-> !busy_o ##1 !handler_start_o)
    else $error("handler start not a clean pulse");
  vector_load_a: assert property (mem_req_o && mem_ack_i && !mem_write_o
    && !mem_program_space_o |=> handler_start_o && pc_o == $past(mem_rdata_i)
    && program_bank_field_o == 4'h0) else $error("vector not loaded");
  reset_z_a: assert property (mem_req_o && mem_ack_i && mem_program_space_o
    && mem_addr_o == 20'h00006 |=> reset_done_o && z_index_register_o == $past(mem_rdata_i))
    else $error("index register not loaded");
  autovec_num_a: assert property (iack_req_o && iack_ack_i && iack_autovec_i
    && !iack_spurious_i && !iack_uninit_i |=> vector_number_o == {5'h02, $past(iack_level_o)})
    else $error("bad autovector number");
endmodule // evm_mapper_properties

bind evm_exception_mapper evm_mapper_properties u_props (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
  .iack_ack_i(iack_ack_i), .iack_autovec_i(iack_autovec_i), .iack_spurious_i(iack_spurious_i),
  .iack_uninit_i(iack_uninit_i), .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
  .mem_program_space_o(mem_program_space_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .iack_req_o(iack_req_o), .iack_level_o(iack_level_o), .busy_o(busy_o),
  .handler_start_o(handler_start_o), .reset_done_o(reset_done_o),
  .vector_number_o(vector_number_o), .pc_o(pc_o), .program_bank_field_o(program_bank_field_o),
  .z_index_register_o(z_index_register_o)
);

`default_nettype wire

// >>> verification/evm_far_model.sv
// Behavioural memory and interrupting device on the far side of the mapper
`timescale 1ns/100ps
`default_nettype none

module evm_far_model
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] delay_i,
  input wire logic [1:0] iack_mode_i,
  input wire logic [7:0] ivec_i,
  input wire logic mem_req_i,
  input wire logic mem_write_i,
  input wire logic mem_program_space_i,
  input wire logic [19:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  input wire logic iack_req_i,
  output logic iack_ack_o,
  output logic iack_autovec_o,
  output logic iack_spurious_o,
  output logic iack_uninit_o,
  output logic [7:0] iack_vector_o
);
  logic [3:0] mcnt;
  logic [3:0] icnt;
  logic [15:0] last;
  logic [15:0] word;

  assign word = mem_program_space_i ? (16'hC3A5 ^ mem_addr_i[15:0])
    : (16'h8000 | mem_addr_i[15:0]);
  assign mem_ack_o = mem_req_i && (mcnt == delay_i);
  // Released data line shows inverted data so stale values never match
  assign mem_rdata_o = (mem_ack_o && !mem_write_i) ? word : ~last;
  assign iack_ack_o = iack_req_i && (icnt == delay_i);
  assign iack_vector_o = iack_ack_o ? ivec_i : ~ivec_i;
  assign iack_autovec_o = iack_ack_o && (iack_mode_i == 2'h1);
  assign iack_spurious_o = iack_ack_o && (iack_mode_i == 2'h2);
  assign iack_uninit_o = iack_ack_o && (iack_mode_i == 2'h3);

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i || !mem_req_i || mem_ack_o)
      mcnt <= 4'h0;
    else
      mcnt <= mcnt + 4'h1;
    if (!nrst_i || !iack_req_i || iack_ack_o)
      icnt <= 4'h0;
    else
      icnt <= icnt + 4'h1;
    if (mem_ack_o)
      last <= mem_rdata_o;
  end
endmodule // evm_far_model

`default_nettype wire

// >>> verification/exception_vector_mapper_test.sv
// Self-checking bench for the exception vector mapper
`timescale 1ns/100ps
`default_nettype none

module exception_vector_mapper_test;
  logic mclk_i = 1'h0, nrst_i = 1'h0, berr_pin_i = 1'h0, bkpt_pin_i = 1'h0;
  logic swi_i = 1'h0, illegal_i = 1'h0, div_zero_i = 1'h0, insn_boundary_i = 1'h1;
  logic [2:0] irq_level_pin_i = 3'h0, irq_mask_i = 3'h0;
  logic [3:0] delay = 4'h0, stack_bank_field_i = 4'h2;
  logic [1:0] imode = 2'h1;
  logic [7:0] ivec = 8'h38;
  logic [19:0] next_insn_addr_i = 20'h5ABCD;
  logic [15:0] condition_flags_register_i = 16'h1235, sp_i = 16'h0800;
  wire mem_ack_i, iack_ack_i, iack_autovec_i, iack_spurious_i, iack_uninit_i;
  wire mem_req_o, mem_write_o, mem_program_space_o, iack_req_o, busy_o, handler_start_o;
  wire reset_done_o;
  wire [15:0] mem_rdata_i, mem_wdata_o, pc_o, sp_o, z_index_register_o;
  wire [7:0] iack_vector_i, vector_number_o;
  wire [19:0] mem_addr_o;
  wire [2:0] iack_level_o;
  wire [3:0] program_bank_field_o, stack_bank_field_o, z_index_bank_field_o;
  int failures = 0, n_compared = 0, cycles = 0;
  logic [37:0] log_q[$];

  evm_exception_mapper u_dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .berr_pin_i(berr_pin_i), .bkpt_pin_i(bkpt_pin_i),
    .irq_level_pin_i(irq_level_pin_i), .swi_i(swi_i), .illegal_i(illegal_i),
    .div_zero_i(div_zero_i), .irq_mask_i(irq_mask_i), .insn_boundary_i(insn_boundary_i),
    .next_insn_addr_i(next_insn_addr_i), .condition_flags_register_i(condition_flags_register_i),
    .sp_i(sp_i), .stack_bank_field_i(stack_bank_field_i), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .iack_ack_i(iack_ack_i), .iack_autovec_i(iack_autovec_i),
    .iack_spurious_i(iack_spurious_i), .iack_uninit_i(iack_uninit_i),
    .iack_vector_i(iack_vector_i), .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
    .mem_program_space_o(mem_program_space_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .iack_req_o(iack_req_o), .iack_level_o(iack_level_o),
    .busy_o(busy_o), .handler_start_o(handler_start_o), .reset_done_o(reset_done_o),
    .vector_number_o(vector_number_o), .pc_o(pc_o), .program_bank_field_o(program_bank_field_o),
    .stack_bank_field_o(stack_bank_field_o), .z_index_bank_field_o(z_index_bank_field_o),
    .sp_o(sp_o), .z_index_register_o(z_index_register_o));

  evm_far_model u_far (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .delay_i(delay), .iack_mode_i(imode), .ivec_i(ivec),
    .mem_req_i(mem_req_o), .mem_write_i(mem_write_o), .mem_program_space_i(mem_program_space_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i),
    .iack_req_i(iack_req_o), .iack_ack_o(iack_ack_i), .iack_autovec_o(iack_autovec_i),
    .iack_spurious_o(iack_spurious_i), .iack_uninit_o(iack_uninit_i),
    .iack_vector_o(iack_vector_i));

  always #2 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Every completed memory transfer: write, space, address, data
  always @(posedge mclk_i)
  begin
    if (mem_req_o === 1'h1 && mem_ack_i === 1'h1)
      log_q.push_back({mem_write_o, mem_program_space_o, mem_addr_o,
                       mem_write_o ? mem_wdata_o : mem_rdata_i});
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Same contents the far model serves
  function automatic logic [15:0] mw(input logic ps, input logic [19:0] a);
    return ps ? (16'hC3A5 ^ a[15:0]) : (16'h8000 | a[15:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // One exception from trigger to handler hand-over, checking every transfer
  task automatic run_exc(input logic [7:0] vec, input logic [19:0] ret);
    int i;
    logic [19:0] va;
    va = {11'h000, vec, 1'h0};
    log_q.delete();
    i = 0;
    do
    begin
      tick(1);
      {swi_i, illegal_i, div_zero_i} = 3'h0;
      // Interrupting device withdraws its request once acknowledged
      if (iack_req_o === 1'h1)
        irq_level_pin_i = 3'h0;
      i++;
    end
    while (handler_start_o !== 1'h1 && i < 300);
    chk(i < 300, 1'h1);
    chk(log_q.size(), 3);
    if (log_q.size() == 3)
    begin
      chk(log_q[0], {2'h2, stack_bank_field_i, sp_i, condition_flags_register_i});
      chk(log_q[1], {2'h2, stack_bank_field_i, sp_i - 16'h2, ret[15:0]});
      chk(log_q[2], {2'h0, va, mw(1'h0, va)});
    end
    chk({pc_o, program_bank_field_o, vector_number_o}, {mw(1'h0, va), 4'h0, vec});
    chk(sp_o, sp_i - 16'h4);
  endtask

  task automatic t_reset();
    int i;
    nrst_i = 1'h0;
    tick(4);
    log_q.delete();
    nrst_i = 1'h1;
    i = 0;
    do
    begin
      tick(1);
      i++;
    end
    while (reset_done_o !== 1'h1 && i < 100);
    chk(log_q.size(), 4);
    for (int k = 0; k < 4 && k < log_q.size(); k++)
      chk(log_q[k], {2'h1, 20'(2 * k), mw(1'h1, 20'(2 * k))});
    chk({z_index_bank_field_o, stack_bank_field_o, program_bank_field_o}, 12'h3A5);
    chk({pc_o, sp_o}, {mw(1'h1, 20'h2), mw(1'h1, 20'h4)});
    chk(z_index_register_o, mw(1'h1, 20'h6));
  endtask

  task automatic t_sync_async();
    swi_i = 1'h1;
    run_exc(8'h06, next_insn_addr_i);
    illegal_i = 1'h1;
    run_exc(8'h07, next_insn_addr_i);
    div_zero_i = 1'h1;
    run_exc(8'h08, next_insn_addr_i);
    delay = 4'h2;
    berr_pin_i = 1'h1;
    run_exc(8'h05, next_insn_addr_i + 20'h6);
    berr_pin_i = 1'h0;
    bkpt_pin_i = 1'h1;
    run_exc(8'h04, next_insn_addr_i + 20'h6);
    bkpt_pin_i = 1'h0;
  endtask

  // Three pending at once must come out in priority order
  task automatic t_prio();
    insn_boundary_i = 1'h0;
    div_zero_i = 1'h1;
    tick(1);
    div_zero_i = 1'h0;
    // Breakpoint pin must be seen low for an edge before it rises again
    {berr_pin_i, bkpt_pin_i} = 2'h3;
    tick(6);
    chk(busy_o, 1'h0);
    insn_boundary_i = 1'h1;
    run_exc(8'h05, next_insn_addr_i + 20'h6);
    run_exc(8'h04, next_insn_addr_i + 20'h6);
    {berr_pin_i, bkpt_pin_i} = 2'h0;
    run_exc(8'h08, next_insn_addr_i);
  endtask

  task automatic irq_once(input logic [1:0] m, input logic [7:0] v, input logic [2:0] l,
                          input logic [7:0] exp);
    imode = m;
    ivec = v;
    irq_level_pin_i = l;
    run_exc(exp, next_insn_addr_i + 20'h6);
  endtask

  task automatic t_irq();
    delay = 4'h3;
    for (int l = 1; l < 8; l++)
      irq_once(2'h1, 8'h00, 3'(l), 8'(8'h10 + l));
    irq_mask_i = 3'h5;
    irq_level_pin_i = 3'h3;
    tick(10);
    chk(busy_o, 1'h0);
    irq_mask_i = 3'h7;
    irq_once(2'h1, 8'h00, 3'h7, 8'h17);
    irq_mask_i = 3'h0;
    delay = 4'h0;
    irq_once(2'h0, 8'h38, 3'h4, 8'h38);
    irq_once(2'h0, 8'hFF, 3'h2, 8'hFF);
    irq_once(2'h2, 8'h38, 3'h5, 8'h18);
    irq_once(2'h3, 8'h38, 3'h6, 8'h0F);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_reset();
    t_sync_async();
    t_prio();
    t_irq();
    swi_i = 1'h1;
    tick(1);
    swi_i = 1'h0;
    tick(2);
    // Reset lands in the middle of stacking
    t_reset();
    tick(10);
    chk(busy_o, 1'h0);
    report_and_stop();
  end
endmodule // exception_vector_mapper_test

`default_nettype wire
